// file: src/acs_pkg.sv
// Constants shared by the audio clock source selector
package acs_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned RATE_MIN_HZ = 28_000;
  localparam int unsigned RATE_MAX_HZ = 200_000;
  localparam int unsigned DBL_MIN_HZ  = 56_000;
  localparam int unsigned QUAD_MIN_HZ = 112_000;
  // Shortest and longest accepted sample period in clock cycles
  localparam int unsigned PER_MIN     = CLK_HZ / RATE_MAX_HZ;
  localparam int unsigned PER_MAX     = (CLK_HZ + RATE_MIN_HZ - 1) / RATE_MIN_HZ;
  localparam int unsigned PER_DBL     = CLK_HZ / DBL_MIN_HZ;
  localparam int unsigned PER_QUAD    = CLK_HZ / QUAD_MIN_HZ;
  localparam int unsigned PER_W       = 11;
  localparam int unsigned SYNC_TOL    = 4;

  // ***************************************************************
  // Sources and lock states
  // ***************************************************************
  localparam int unsigned NUM_SRC  = 5;
  localparam logic [2:0]  SRC_MC   = 3'h0;
  localparam logic [2:0]  SRC_AES  = 3'h1;
  localparam logic [2:0]  SRC_SPDIF = 3'h2;
  localparam logic [2:0]  SRC_WCT  = 3'h3;
  localparam logic [2:0]  SRC_SYNC = 3'h4;
  localparam logic [1:0]  LK_NONE  = 2'h0;
  localparam logic [1:0]  LK_LOCK  = 2'h1;
  localparam logic [1:0]  LK_SYNC  = 2'h2;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [5:0] OFS_CTRL  = 6'h00;
  localparam logic [5:0] OFS_BASE  = 6'h04;
  localparam logic [5:0] OFS_FADER = 6'h08;
  localparam logic [5:0] OFS_STAT  = 6'h0C;
  localparam logic [5:0] OFS_PER0  = 6'h10;
  localparam logic [5:0] OFS_SYSPER = 6'h24;
  localparam logic [5:0] OFS_RATE  = 6'h28;
  localparam logic [5:0] OFS_IRQS  = 6'h2C;
  localparam logic [5:0] OFS_IRQM  = 6'h30;

  // ***************************************************************
  // Control fields and reset values
  // ***************************************************************
  localparam int unsigned CB_AUTO  = 0;
  localparam int unsigned CB_PREF  = 1;
  localparam int unsigned CB_SPIN  = 4;
  localparam int unsigned CB_SPOPT = 6;
  localparam int unsigned CB_MCEXP = 7;
  localparam int unsigned CB_SSPD  = 8;
  localparam int unsigned CB_PASS  = 9;
  localparam int unsigned CB_DDS   = 10;
  localparam int unsigned CB_MULT  = 11;
  localparam int unsigned CB_FADE  = 13;
  localparam logic [13:0] CTRL_RST = 14'h0000;
  localparam logic [17:0] BASE_RST = 18'h0BB80;
  localparam logic [15:0] FADE_RST = 16'h0000;
  localparam logic [5:0]  IRQ_RST  = 6'h00;

endpackage

// file: src/acs_clock_selector.sv
// Clock source selection, lock monitor and synthesized rate generator
//
// Functional notes
// - Manual mode runs from internal clock; auto-slave follows the preferred reference.
// - Auto-slave scans all inputs and slaves to a valid one.
// - Lost slave input returns to internal clock and master state at once.
// - Preferred input is used while valid, otherwise others scanned in turn.
// - Fall back to next available source; report current source and rate.
// - Candidates: multichannel optical, AES, SPDIF, word/timecode, internal sync.
// - No valid input leaves the device in master mode.
// - Each input reports no signal, locked, or locked and synchronous.
// - Incoming sample period of each input is measured and readable.
// - Word clock out equals system rate, or divided into single speed range.
// - Any rate from 28 kHz to 200 kHz is accepted and tracked.
// - Synthesized rate is base; with DDS set, base plus optional fader offset, times multiplier, 1 Hz steps.
// - Multiplier selects single, double or quad speed.
// - Synthesized settings are taken up only while in master mode.
// - SPDIF input chosen from optical, coaxial or internal header.
// - SPDIF out always on coaxial, also on optical when selected.
// - Multichannel optical input can be switched to the expansion connector.
// - Passthrough option forwards channel status and track markers of SPDIF and AES.
`timescale 1ns/1ps
module acs_clock_selector (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Recovered sample clocks from the receivers
  input  wire logic        mc_opt_wc,
  input  wire logic        mc_exp_wc,
  input  wire logic        aes_wc,
  input  wire logic        spdif_opt_wc,
  input  wire logic        spdif_coax_wc,
  input  wire logic        spdif_hdr_wc,
  input  wire logic        wct_wc,
  input  wire logic        sync_int_wc,
  // SPDIF transmit path
  input  wire logic        spdif_tx,
  output logic             spdif_coax_tx,
  output logic             spdif_opt_tx,
  // Channel status and marker passthrough
  input  wire logic        spdif_cs,
  input  wire logic        spdif_mark,
  input  wire logic        aes_cs,
  input  wire logic        aes_mark,
  output logic             spdif_cs_fwd,
  output logic             spdif_mark_fwd,
  output logic             aes_cs_fwd,
  output logic             aes_mark_fwd,
  // Clock outputs and status
  output logic             sys_wc,
  output logic             word_clk_out,
  output logic             slave_active,
  output logic             irq
);

  localparam int NS = acs_pkg::NUM_SRC;

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [13:0]              ctrl;
  logic [17:0]              base_hz;
  logic signed [15:0]       fader;
  logic [5:0]               irq_stat;
  logic [5:0]               irq_mask;
  logic [2:0]               cur_src;
  logic [2:0]               scan_ptr;
  logic [19:0]              nco_rate;
  logic [26:0]              nco_acc;
  logic                     nco_lvl;
  logic [1:0]               div_cnt;
  logic [NS-1:0]            lck_prev;
  logic                     slave_prev;
  logic                     sys_prev;

  logic [NS:0]              m_lvl;
  logic [NS:0]              lck;
  logic [acs_pkg::PER_W-1:0] per [NS+1];
  logic [NS-1:0]            sy;
  logic [2:0]               pref;
  logic [31:0]              rd_val;
  logic [19:0]              next_rate;
  logic [26:0]              next_acc;
  logic signed [19:0]       synth_sum;
  logic [5:0]               irq_ev;
  logic [4:0]               pin_raw;

  assign pref = ctrl[acs_pkg::CB_PREF +: 3];

  // ***************************************************************
  // Input path selection and synchronisers
  // ***************************************************************
  always_comb begin
    pin_raw[acs_pkg::SRC_MC] = ctrl[acs_pkg::CB_MCEXP] ? mc_exp_wc : mc_opt_wc;
    pin_raw[acs_pkg::SRC_AES] = aes_wc;
    unique case (ctrl[acs_pkg::CB_SPIN +: 2])
      2'h0:    pin_raw[acs_pkg::SRC_SPDIF] = spdif_opt_wc;
      2'h1:    pin_raw[acs_pkg::SRC_SPDIF] = spdif_coax_wc;
      default: pin_raw[acs_pkg::SRC_SPDIF] = spdif_hdr_wc;
    endcase
    pin_raw[acs_pkg::SRC_WCT] = wct_wc;
    pin_raw[acs_pkg::SRC_SYNC] = sync_int_wc;
  end

  // Two flops per selected source after the path muxes; only the muxes read the raw pins
  logic [NS-1:0] sync_a;
  logic [NS-1:0] sync_b;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
    end
  end

  assign m_lvl = {sys_wc, sync_b};

  // ***************************************************************
  // Period measurement and lock detection per input
  // ***************************************************************
  genvar gi;
  generate
    for (gi = 0; gi <= NS; gi++) begin : g_meas
      logic                      prev;
      logic [acs_pkg::PER_W-1:0] cnt;
      logic                      lk;
      logic [acs_pkg::PER_W-1:0] pr;

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          prev <= 1'b0;
          cnt  <= '0;
          lk   <= 1'b0;
          pr   <= '0;
        end else begin
          prev <= m_lvl[gi];
          if (m_lvl[gi] && !prev) begin
            cnt <= '0;
            pr  <= cnt;
            lk  <= (cnt >= acs_pkg::PER_W'(acs_pkg::PER_MIN - 1)) &&
                   (cnt <= acs_pkg::PER_W'(acs_pkg::PER_MAX - 1));
          end else if (cnt > acs_pkg::PER_W'(acs_pkg::PER_MAX)) begin
            lk <= 1'b0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      end

      assign lck[gi] = lk;
      assign per[gi] = pr;
    end
  endgenerate

  // Synchronous state against the measured system clock
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      logic [acs_pkg::PER_W-1:0] diff;
      assign diff = (per[gi] > per[NS]) ? per[gi] - per[NS] : per[NS] - per[gi];
      assign sy[gi] = lck[gi] && lck[NS] &&
                      (diff <= acs_pkg::PER_W'(acs_pkg::SYNC_TOL));
    end
  endgenerate

  // ***************************************************************
  // Source selection
  // ***************************************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      slave_active <= 1'b0;
      cur_src      <= acs_pkg::SRC_MC;
      scan_ptr     <= acs_pkg::SRC_MC;
    end else begin
      scan_ptr <= (scan_ptr == 3'(NS - 1)) ? 3'h0 : scan_ptr + 3'h1;
      if (!ctrl[acs_pkg::CB_AUTO]) begin
        slave_active <= 1'b0;
      end else if (slave_active && !lck[cur_src]) begin
        slave_active <= 1'b0;
      end else if (pref < 3'(NS) && lck[pref]) begin
        cur_src      <= pref;
        slave_active <= 1'b1;
      end else if (!slave_active && lck[scan_ptr]) begin
        cur_src      <= scan_ptr;
        slave_active <= 1'b1;
      end
      // With no locked input no branch sets slave_active: master stays
    end
  end

  // ***************************************************************
  // Synthesized internal rate
  // ***************************************************************
  always_comb begin
    synth_sum = $signed({2'b00, base_hz}) +
                (ctrl[acs_pkg::CB_FADE] ? 20'(fader) : 20'sh00000);
    next_rate = {2'b00, base_hz};
    if (ctrl[acs_pkg::CB_DDS]) begin
      unique case (ctrl[acs_pkg::CB_MULT +: 2])
        2'h1:    next_rate = 20'(synth_sum <<< 1);
        2'h2:    next_rate = 20'(synth_sum <<< 2);
        default: next_rate = 20'(synth_sum);
      endcase
    end
    next_acc = nco_acc + {6'h00, nco_rate, 1'b0};
  end

  // Rate frozen while slaved to an input
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      nco_rate <= {2'b00, acs_pkg::BASE_RST};
    end else if (!slave_active) begin
      nco_rate <= next_rate;
    end
  end

  // Toggles twice per period, exact to 1 Hz
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      nco_acc <= '0;
      nco_lvl <= 1'b0;
    end else if (next_acc >= 27'(acs_pkg::CLK_HZ)) begin
      nco_acc <= next_acc - 27'(acs_pkg::CLK_HZ);
      nco_lvl <= !nco_lvl;
    end else begin
      nco_acc <= next_acc;
    end
  end

  // ***************************************************************
  // System and word clock outputs
  // ***************************************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sys_wc       <= 1'b0;
      sys_prev     <= 1'b0;
      div_cnt      <= 2'h0;
      word_clk_out <= 1'b0;
    end else begin
      sys_wc <= slave_active ? sync_b[cur_src] : nco_lvl;
      sys_prev <= sys_wc;
      // Divider steps on each rising edge of the system clock
      if (sys_wc && !sys_prev) begin
        div_cnt <= div_cnt + 2'h1;
      end
      if (!ctrl[acs_pkg::CB_SSPD] || !lck[NS] ||
          per[NS] > acs_pkg::PER_W'(acs_pkg::PER_DBL)) begin
        word_clk_out <= sys_wc;
      end else if (per[NS] > acs_pkg::PER_W'(acs_pkg::PER_QUAD)) begin
        word_clk_out <= div_cnt[0];
      end else begin
        word_clk_out <= div_cnt[1];
      end
    end
  end

  // ***************************************************************
  // SPDIF output and status passthrough
  // ***************************************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      spdif_coax_tx  <= 1'b0;
      spdif_opt_tx   <= 1'b0;
      spdif_cs_fwd   <= 1'b0;
      spdif_mark_fwd <= 1'b0;
      aes_cs_fwd     <= 1'b0;
      aes_mark_fwd   <= 1'b0;
    end else begin
      spdif_coax_tx  <= spdif_tx;
      spdif_opt_tx   <= ctrl[acs_pkg::CB_SPOPT] & spdif_tx;
      spdif_cs_fwd   <= ctrl[acs_pkg::CB_PASS] & spdif_cs;
      spdif_mark_fwd <= ctrl[acs_pkg::CB_PASS] & spdif_mark;
      aes_cs_fwd     <= ctrl[acs_pkg::CB_PASS] & aes_cs;
      aes_mark_fwd   <= ctrl[acs_pkg::CB_PASS] & aes_mark;
    end
  end

  // ***************************************************************
  // Interrupts
  // ***************************************************************
  assign irq_ev = {slave_active ^ slave_prev, lck[NS-1:0] ^ lck_prev};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lck_prev   <= '0;
      slave_prev <= 1'b0;
      irq_stat   <= acs_pkg::IRQ_RST;
      irq        <= 1'b0;
    end else begin
      lck_prev   <= lck[NS-1:0];
      slave_prev <= slave_active;
      // Set wins over a clear in the same cycle
      if (reg_wr && reg_addr == acs_pkg::OFS_IRQS) begin
        irq_stat <= (irq_stat & ~reg_wdata[5:0]) | irq_ev;
      end else begin
        irq_stat <= irq_stat | irq_ev;
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ***************************************************************
  // Register writes
  // ***************************************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl     <= acs_pkg::CTRL_RST;
      base_hz  <= acs_pkg::BASE_RST;
      fader    <= acs_pkg::FADE_RST;
      irq_mask <= acs_pkg::IRQ_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        acs_pkg::OFS_CTRL:  ctrl     <= reg_wdata[13:0];
        acs_pkg::OFS_BASE:  base_hz  <= reg_wdata[17:0];
        acs_pkg::OFS_FADER: fader    <= reg_wdata[15:0];
        acs_pkg::OFS_IRQM:  irq_mask <= reg_wdata[5:0];
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // Register reads
  // ***************************************************************
  always_comb begin
    rd_val = 32'h00000000;
    if (reg_addr >= acs_pkg::OFS_PER0 && reg_addr < acs_pkg::OFS_SYSPER) begin
      for (int i = 0; i < NS; i++) begin
        if (reg_addr[5:2] == 4'(i + 4)) begin
          rd_val = 32'(per[i]);
        end
      end
    end else begin
      unique case (reg_addr)
        acs_pkg::OFS_CTRL:   rd_val = 32'(ctrl);
        acs_pkg::OFS_BASE:   rd_val = 32'(base_hz);
        acs_pkg::OFS_FADER:  rd_val = 32'(fader);
        acs_pkg::OFS_SYSPER: rd_val = 32'(per[NS]);
        acs_pkg::OFS_RATE:   rd_val = 32'(nco_rate);
        acs_pkg::OFS_IRQS:   rd_val = 32'(irq_stat);
        acs_pkg::OFS_IRQM:   rd_val = 32'(irq_mask);
        acs_pkg::OFS_STAT: begin
          rd_val[0]   = slave_active;
          rd_val[3:1] = cur_src;
          for (int i = 0; i < NS; i++) begin
            rd_val[4 + 2 * i +: 2] = sy[i]  ? acs_pkg::LK_SYNC :
                                     lck[i] ? acs_pkg::LK_LOCK : acs_pkg::LK_NONE;
          end
        end
        default: rd_val = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 32'h00000000;
    end
  end

endmodule

// file: bench/acs_wc_source.sv
// Model of one external source delivering a recovered sample clock
`timescale 1ns/1ps
module acs_wc_source (
  // Clock
  input  wire logic clk,
  // Source setting
  input  wire logic on,
  input  int        half,
  // Sample clock
  output logic      wc
);
  int cnt;
  initial wc = 1'b0;
  // Unplugged source holds its line low
  always @(posedge clk) begin
    if (!on) begin
      wc  <= 1'b0;
      cnt <= 0;
    end else if (cnt >= half - 1) begin
      wc  <= ~wc;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// file: bench/acs_clock_selector_properties.sv
// Port-level checker of the clock source selector
`timescale 1ns/1ps
module acs_clock_selector_properties (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Sample clock inputs
  input wire logic        mc_opt_wc,
  input wire logic        mc_exp_wc,
  input wire logic        aes_wc,
  input wire logic        spdif_opt_wc,
  input wire logic        spdif_coax_wc,
  input wire logic        spdif_hdr_wc,
  input wire logic        wct_wc,
  input wire logic        sync_int_wc,
  // Transmit and passthrough
  input wire logic        spdif_tx,
  input wire logic        spdif_coax_tx,
  input wire logic        spdif_opt_tx,
  input wire logic        spdif_cs,
  input wire logic        spdif_mark,
  input wire logic        aes_cs,
  input wire logic        aes_mark,
  input wire logic        spdif_cs_fwd,
  input wire logic        spdif_mark_fwd,
  input wire logic        aes_cs_fwd,
  input wire logic        aes_mark_fwd,
  // Status
  input wire logic        sys_wc,
  input wire logic        slave_active
);
  // ***************************************************************
  // Quiet-time counters
  // ***************************************************************
  logic [7:0]  wcv;
  logic [7:0]  wc_q;
  logic        sys_q;
  logic [10:0] in_quiet;
  logic [10:0] sys_quiet;
  assign wcv = {mc_opt_wc, mc_exp_wc, aes_wc, spdif_opt_wc, spdif_coax_wc, spdif_hdr_wc,
                wct_wc, sync_int_wc};
  always_ff @(posedge ref_clk) begin
    wc_q  <= wcv;
    sys_q <= sys_wc;
    if (sys_rst || wcv != wc_q) begin
      in_quiet <= 11'h000;
    end else if (in_quiet != 11'h7FF) begin
      in_quiet <= in_quiet + 11'h001;
    end
    if (sys_rst || slave_active || sys_wc != sys_q) begin
      sys_quiet <= 11'h000;
    end else if (sys_quiet != 11'h7FF) begin
      sys_quiet <= sys_quiet + 11'h001;
    end
  end
  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data seen outside its cycle");
  a_coax_copy: assert property (!$past(sys_rst) |-> spdif_coax_tx == $past(spdif_tx))
    else $error("coaxial output does not follow transmit bit");
  a_opt_gate: assert property (spdif_opt_tx |-> $past(spdif_tx))
    else $error("optical output high without transmit bit");
  a_spdif_fwd: assert property ((spdif_cs_fwd |-> $past(spdif_cs)) and
    (spdif_mark_fwd |-> $past(spdif_mark))) else $error("spdif status forwarded wrongly");
  a_aes_fwd: assert property ((aes_cs_fwd |-> $past(aes_cs)) and
    (aes_mark_fwd |-> $past(aes_mark))) else $error("aes status forwarded wrongly");
  a_lost_master: assert property (in_quiet > 11'h712 |-> !slave_active)
    else $error("still slave with all inputs silent");
  a_slave_entry: assert property ($rose(slave_active) |-> in_quiet < 11'h6FE)
    else $error("slave entered without a live input");
  a_master_nco: assert property (!slave_active |-> sys_quiet < 11'h3E8)
    else $error("internal clock not running in master mode");
endmodule
bind acs_clock_selector acs_clock_selector_properties u_acs_clock_selector_properties (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mc_opt_wc(mc_opt_wc), .mc_exp_wc(mc_exp_wc), .aes_wc(aes_wc), .spdif_opt_wc(spdif_opt_wc),
  .spdif_coax_wc(spdif_coax_wc), .spdif_hdr_wc(spdif_hdr_wc), .wct_wc(wct_wc),
  .sync_int_wc(sync_int_wc), .spdif_tx(spdif_tx), .spdif_coax_tx(spdif_coax_tx),
  .spdif_opt_tx(spdif_opt_tx), .spdif_cs(spdif_cs), .spdif_mark(spdif_mark),
  .aes_cs(aes_cs), .aes_mark(aes_mark), .spdif_cs_fwd(spdif_cs_fwd),
  .spdif_mark_fwd(spdif_mark_fwd), .aes_cs_fwd(aes_cs_fwd), .aes_mark_fwd(aes_mark_fwd),
  .sys_wc(sys_wc), .slave_active(slave_active));

// file: bench/testbench.sv
// Self-checking bench of the clock source selector
`timescale 1ns/1ps
module testbench;
  logic        ref_clk;
  logic        sys_rst;
  logic [5:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [7:0]  src_on;
  logic [4:0]  aux;
  logic        sys_wc;
  logic        word_clk_out;
  logic        slave_active;
  logic        irq;
  wire  [7:0]  wc;
  wire  [5:0]  txo;
  int          half [8];
  int          miscompares;
  int          tests_run;
  int          cycles;
  logic [31:0] ctl_t [4] = '{32'h0C00, 32'h1400, 32'h1C00, 32'h2400};
  logic [31:0] hz_t  [4] = '{32'h17700, 32'h2EE00, 32'hBB80, 32'hBBE4};
  for (genvar g = 0; g < 8; g++) begin : g_src
    acs_wc_source u_acs_wc_source (.clk(ref_clk), .on(src_on[g]), .half(half[g]), .wc(wc[g]));
  end
  acs_clock_selector u_acs_clock_selector (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mc_opt_wc(wc[0]),
    .mc_exp_wc(wc[1]), .aes_wc(wc[2]), .spdif_opt_wc(wc[3]), .spdif_coax_wc(wc[4]),
    .spdif_hdr_wc(wc[5]), .wct_wc(wc[6]), .sync_int_wc(wc[7]), .spdif_tx(aux[4]),
    .spdif_coax_tx(txo[5]), .spdif_opt_tx(txo[4]), .spdif_cs(aux[3]), .spdif_mark(aux[2]),
    .aes_cs(aux[1]), .aes_mark(aux[0]), .spdif_cs_fwd(txo[3]), .spdif_mark_fwd(txo[2]),
    .aes_cs_fwd(txo[1]), .aes_mark_fwd(txo[0]), .sys_wc(sys_wc),
    .word_clk_out(word_clk_out), .slave_active(slave_active), .irq(irq));
  // ***************************************************************
  // Bus and check tasks
  // ***************************************************************
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask
  task automatic lk(input int i, input logic [1:0] e);
    logic [31:0] v;
    rd(acs_pkg::OFS_STAT, v);
    chk(v[4 + 2 * i +: 2], e);
  endtask
  task automatic sel(input logic [3:0] e);
    logic [31:0] v;
    rd(acs_pkg::OFS_STAT, v);
    chk(v[3:0], e);
  endtask
  task automatic wclk(input int e);
    int   n;
    logic p;
    n = 0;
    p = word_clk_out;
    repeat (10420) begin
      @(posedge ref_clk);
      if (word_clk_out && !p) n++;
      p = word_clk_out;
    end
    chk({31'h0, n >= e - 1 && n <= e + 1}, 32'h1);
  endtask
  // ***************************************************************
  // Clock, timeout and test sequence
  // ***************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    sys_rst   = 1'b1;
    reg_addr  = 6'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    src_on    = 8'h00;
    aux       = 5'h00;
    foreach (half[i]) half[i] = 260;
    half[0] = 500;
    cyc(8);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk({irq, slave_active}, 32'h0);
    rc(acs_pkg::OFS_CTRL, 32'h0);
    rc(acs_pkg::OFS_BASE, 32'hBB80);
    rc(6'h3C, 32'h0);
    rc(acs_pkg::OFS_IRQM, 32'h0);
    src_on <= 8'h04;
    cyc(3000);
    lk(1, acs_pkg::LK_LOCK);
    chk(slave_active, 32'h0);
    rc(acs_pkg::OFS_PER0 + 6'h04, 32'h207);
    rc(acs_pkg::OFS_IRQS, 32'h2);
    chk(irq, 32'h0);
    wr(acs_pkg::OFS_IRQM, 32'h3F);
    cyc(3);
    chk(irq, 32'h1);
    wr(acs_pkg::OFS_IRQS, 32'h3F);
    rc(acs_pkg::OFS_IRQS, 32'h0);
    chk(irq, 32'h0);
    wr(acs_pkg::OFS_CTRL, 32'h1);
    cyc(3000);
    sel({acs_pkg::SRC_AES, 1'b1});
    lk(1, acs_pkg::LK_SYNC);
    chk(irq, 32'h1);
    wr(acs_pkg::OFS_BASE, 32'h17700);
    rc(acs_pkg::OFS_RATE, 32'hBB80);
    src_on <= 8'h05;
    cyc(3000);
    sel({acs_pkg::SRC_MC, 1'b1});
    src_on <= 8'h04;
    cyc(3000);
    sel({acs_pkg::SRC_AES, 1'b1});
    src_on <= 8'h00;
    cyc(3000);
    chk(slave_active, 32'h0);
    rc(acs_pkg::OFS_RATE, 32'h17700);
    wr(acs_pkg::OFS_CTRL, 32'h9);
    src_on <= 8'h40;
    cyc(3000);
    sel({acs_pkg::SRC_WCT, 1'b1});
    src_on <= 8'hC0;
    cyc(3000);
    sel({acs_pkg::SRC_SYNC, 1'b1});
    src_on <= 8'h00;
    wr(acs_pkg::OFS_CTRL, 32'h0);
    cyc(3000);
    wclk(20);
    wr(acs_pkg::OFS_CTRL, 32'h100);
    wclk(10);
    wr(acs_pkg::OFS_BASE, 32'hBB80);
    wr(acs_pkg::OFS_FADER, 32'h64);
    for (int k = 0; k < 4; k++) begin
      wr(acs_pkg::OFS_CTRL, ctl_t[k]);
      cyc(2);
      rc(acs_pkg::OFS_RATE, hz_t[k]);
    end
    aux <= 5'h1F;
    wr(acs_pkg::OFS_CTRL, 32'h240);
    cyc(2);
    chk(txo, 32'h3F);
    wr(acs_pkg::OFS_CTRL, 32'h0);
    cyc(2);
    chk(txo, 32'h20);
    for (int k = 0; k < 3; k++) begin
      src_on <= 8'h08 << k;
      wr(acs_pkg::OFS_CTRL, 32'(k << 4));
      cyc(3000);
      lk(2, acs_pkg::LK_LOCK);
      wr(acs_pkg::OFS_CTRL, 32'(((k + 1) % 3) << 4));
      cyc(3000);
      lk(2, acs_pkg::LK_NONE);
    end
    src_on <= 8'h02;
    wr(acs_pkg::OFS_CTRL, 32'h80);
    cyc(3000);
    lk(0, acs_pkg::LK_LOCK);
    wr(acs_pkg::OFS_CTRL, 32'h0);
    cyc(3000);
    lk(0, acs_pkg::LK_NONE);
    close_out();
  end
endmodule
